/* core/stack_power_mode_sequencer.v */
// Behaviour
// - During init, sample chain clock pin: pulled low means secondary, floating means primary.
// - Secondary always runs forced PWM, whatever the configuration says.
// - Chain clock passes downstream, shifted about 140 degrees from incoming clock.
// - Hold shared enable low during start-up or fault.
// - Primary holds compensation low while enable low, drives it once high.
// - All pull power-good low during init; afterwards only primary drives it.
// - Secondary moves from discontinuous to continuous on power-good rising edge.
// - Lockouts and thermal shutdown pull enable low; current limit only clamps amplifier.
// - Secondary keeps discharge on; enable is a plain binary input in stack.
// - Only primary runs window comparator, serial interface and voltage scaling.
// - Spread spectrum and external sync reach secondaries through the chain clock.
// - Below power-on threshold nothing works; above it go to lockout mode.
// - Lockout mode keeps registers; discharge only when entered from standby or on mode.
// - Lockout goes to power-on reset below threshold; above lockout to standby if initialized, else init.
// - First lockout crossing after power-on starts 400 us init sampling strap pins.
// - A lockout dip without power-on reset does not repeat initialization.
// - Initialized, above lockout: standby if enable low, switching off, hot or overvoltage.
// - Standby keeps serial interface, discharge and power-good working.
// - On mode only with enable high, switching on, cool and not overvoltage.
// - On mode falls to standby on failed condition, to lockout on low supply.
// - Thermal shutdown pulls enable low only when standalone bit is 0.
`timescale 1ns/1ps
`include "stack_seq_defines.vh"

module stack_power_mode_sequencer #(
    parameter INIT_CYC = `INIT_TIME_US * `PCLK_MHZ,
    parameter CW = 10
)(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire supply_above_por,
    input wire supply_above_undervoltage_lockout,
    input wire supply_above_overvoltage_lockout,
    input wire thermal_shutdown,
    input wire current_limit,
    input wire soft_start_done,
    input wire window_in_range,
    input wire en_i,
    output reg en_o,
    output reg en_oe,
    input wire pwr_good_line_i,
    output reg pwr_good_line_o,
    output reg pwr_good_line_oe,
    input wire chain_clk_i,
    output reg chain_clk_o,
    output reg chain_clk_oe,
    input wire mode_sync_i,
    input wire freq_select_pin,
    input wire voltage_select_pin,
    output reg [2:0] mode,
    output reg secondary,
    output reg switching,
    output reg forced_pwm,
    output reg continuous_conduction,
    output reg comp_hold_low,
    output reg comp_drive,
    output reg err_amp_clamp,
    output reg out_discharge,
    output reg precise_enable,
    output reg window_cmp_en,
    output reg serial_if_en,
    output reg dynamic_voltage_scaling_en,
    output reg spread_spectrum_clocking_en
);

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    localparam NS = 13;
    wire [NS-1:0] async_in;
    reg [NS-1:0] meta_q;
    reg [NS-1:0] sync_q;

    assign async_in = {supply_above_por, supply_above_undervoltage_lockout, supply_above_overvoltage_lockout,
        thermal_shutdown, current_limit, soft_start_done, window_in_range,
        en_i, pwr_good_line_i, chain_clk_i, mode_sync_i, freq_select_pin, voltage_select_pin};

    // Two stages per pin; only the second stage feeds logic
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= {NS{1'b0}};
            sync_q <= {NS{1'b0}};
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    wire por_ok = sync_q[12];
    wire undervoltage_lockout_ok = sync_q[11];
    wire overvoltage_lockout = sync_q[10];
    wire tshut = sync_q[9];
    wire ilim = sync_q[8];
    wire ss_done = sync_q[7];
    wire win_ok = sync_q[6];
    wire en_s = sync_q[5];
    wire pg_s = sync_q[4];
    wire chain_s = sync_q[3];
    wire msync_s = sync_q[2];
    wire freq_select_pin_s = sync_q[1];

    ////////////////////////////////////////////////////////////////////
    // Registers and APB slave
    reg [`CTRL_W-1:0] ctrl_q;
    reg [2:0] mode_q;
    reg init_done_q;
    reg sec_q;
    reg freq_select_pin_q;
    reg voltage_select_pin_lat_q;
    reg ccm_q;

    wire switching_enable_bit = ctrl_q[`CTRL_SWITCHING_ENABLE_BIT];
    wire standalone = ctrl_q[`CTRL_STANDALONE];
    wire stacked = ~standalone | sec_q;
    wire acc = psel & penable & ~pready;
    wire hit_ctrl = (paddr == `OFS_CTRL);
    wire hit_stat = (paddr == `OFS_STAT);

    wire [31:0] stat_word = {22'h000000, voltage_select_pin_lat_q, freq_select_pin_q, pg_s, en_s, ccm_q,
        init_done_q, sec_q, mode_q};

    // One wait state: pready rises in the second access cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            ctrl_q <= `CTRL_RST;
        end
        else
        begin
            pready <= acc;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (!por_ok)
                ctrl_q <= `CTRL_RST;
            if (acc)
            begin
                if (pwrite)
                begin
                    // Secondaries ignore the serial path, so writes are refused
                    if (hit_ctrl && !sec_q)
                        ctrl_q <= pwdata[`CTRL_W-1:0];
                    else
                        pslverr <= 1'b1;
                end
                else if (hit_ctrl)
                    prdata <= {27'h0000000, ctrl_q};
                else if (hit_stat)
                    prdata <= stat_word;
                else
                    pslverr <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mode sequencer
    reg [2:0] mode_d;
    reg [31:0] init_cnt_q;
    reg from_stby_q;
    wire run_ok = en_s & switching_enable_bit & ~tshut & ~overvoltage_lockout;

    always @*
    begin
        mode_d = mode_q;
        case (mode_q)
            `MODE_POR:
                if (por_ok)
                    mode_d = `MODE_UNDERVOLTAGE_LOCKOUT;
            `MODE_UNDERVOLTAGE_LOCKOUT:
                if (!por_ok)
                    mode_d = `MODE_POR;
                else if (undervoltage_lockout_ok)
                    mode_d = init_done_q ? `MODE_STBY : `MODE_INIT;
            `MODE_INIT:
                if (!por_ok)
                    mode_d = `MODE_POR;
                else if (!undervoltage_lockout_ok)
                    mode_d = `MODE_UNDERVOLTAGE_LOCKOUT;
                else if (init_cnt_q >= INIT_CYC - 1)
                    mode_d = `MODE_STBY;
            `MODE_STBY:
                if (!por_ok)
                    mode_d = `MODE_POR;
                else if (!undervoltage_lockout_ok)
                    mode_d = `MODE_UNDERVOLTAGE_LOCKOUT;
                else if (run_ok)
                    mode_d = `MODE_ON;
            `MODE_ON:
                if (!por_ok)
                    mode_d = `MODE_POR;
                else if (!undervoltage_lockout_ok)
                    mode_d = `MODE_UNDERVOLTAGE_LOCKOUT;
                else if (!run_ok)
                    mode_d = `MODE_STBY;
            default:
                mode_d = `MODE_POR;
        endcase
    end

    // Mode, init timer, strap and role latches
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q <= `MODE_POR;
            init_cnt_q <= 32'h00000000;
            init_done_q <= 1'b0;
            from_stby_q <= 1'b0;
            sec_q <= 1'b0;
            freq_select_pin_q <= 1'b0;
            voltage_select_pin_lat_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            if (mode_q == `MODE_INIT)
                init_cnt_q <= init_cnt_q + 32'h00000001;
            else
                init_cnt_q <= 32'h00000000;
            if (mode_q == `MODE_INIT && mode_d == `MODE_STBY)
            begin
                init_done_q <= 1'b1;
                sec_q <= ~chain_s;
                freq_select_pin_q <= freq_select_pin_s;
                voltage_select_pin_lat_q <= sync_q[0]; // Voltage strap
            end
            if (mode_d == `MODE_POR)
            begin
                init_done_q <= 1'b0;
                sec_q <= 1'b0;
            end
            if (mode_d == `MODE_UNDERVOLTAGE_LOCKOUT && mode_q != `MODE_UNDERVOLTAGE_LOCKOUT)
                from_stby_q <= init_done_q && mode_q != `MODE_INIT;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Chain clock: measure incoming period, re-emit shifted
    reg msync_d_q;
    reg [CW-1:0] pcnt_q;
    reg [CW-1:0] period_q;
    reg sync_seen_q;
    reg [CW-1:0] ph_q;
    reg ssc_alt_q;
    wire in_rise = msync_s & ~msync_d_q;
    wire follow = sec_q | sync_seen_q;
    wire [CW-1:0] int_period = `SW_PERIOD_DEF + {{(CW-1){1'b0}},
        ssc_alt_q & spread_spectrum_clocking_en};
    wire [CW-1:0] cur_period = follow ? period_q : int_period;
    wire [CW+7:0] prod = cur_period * `PHASE_MUL;
    wire [CW-1:0] dly_raw = prod[CW+7:`PHASE_SHIFT];
    // Pulse pulled earlier by the input path delay, else the offset overshoots 140 degrees
    wire [CW-1:0] dly = (follow && dly_raw > `CHAIN_LAT) ? dly_raw - `CHAIN_LAT : {CW{1'b0}};
    wire [CW-1:0] dly_end = dly + {1'b0, cur_period[CW-1:1]};
    wire int_wrap = (ph_q >= int_period - 1);
    wire ref_ev = follow ? in_rise : int_wrap;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            msync_d_q <= 1'b0;
            pcnt_q <= {CW{1'b0}};
            period_q <= `SW_PERIOD_DEF;
            sync_seen_q <= 1'b0;
            ph_q <= {CW{1'b0}};
            ssc_alt_q <= 1'b0;
        end
        else
        begin
            msync_d_q <= msync_s;
            if (in_rise)
            begin
                period_q <= pcnt_q + {{(CW-1){1'b0}}, 1'b1};
                pcnt_q <= {CW{1'b0}};
                sync_seen_q <= 1'b1;
            end
            else if (pcnt_q >= `SYNC_LOSS_DEF)
                sync_seen_q <= 1'b0; // Lost sync returns a primary to its own oscillator
            else
                pcnt_q <= pcnt_q + {{(CW-1){1'b0}}, 1'b1};
            if (ref_ev)
            begin
                ph_q <= {CW{1'b0}};
                ssc_alt_q <= ~ssc_alt_q; // Dither alternates period length
            end
            else
                ph_q <= ph_q + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stack coordination and function enables
    reg pg_d_q;
    wire pg_rise = pg_s & ~pg_d_q;
    wire is_on = (mode_q == `MODE_ON);
    wire is_stby = (mode_q == `MODE_STBY);
    wire starting = (mode_q == `MODE_INIT) | (mode_q == `MODE_UNDERVOLTAGE_LOCKOUT);
    wire fault = ~undervoltage_lockout_ok | overvoltage_lockout | (tshut & ~standalone);
    wire disch_ok = is_stby | (mode_q == `MODE_UNDERVOLTAGE_LOCKOUT & from_stby_q);
    wire disch_cfg = (sec_q & stacked) | ctrl_q[`CTRL_DISCH];
    wire pg_good = is_on & ss_done & win_ok & ~tshut;

    // Conduction mode tracking for secondaries
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pg_d_q <= 1'b0;
            ccm_q <= 1'b0;
        end
        else
        begin
            pg_d_q <= pg_s;
            if (!is_on)
                ccm_q <= 1'b0;
            else if (pg_rise)
                ccm_q <= 1'b1;
        end
    end

    // All top outputs registered
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_o <= 1'b0;
            en_oe <= 1'b0;
            pwr_good_line_o <= 1'b0;
            pwr_good_line_oe <= 1'b0;
            chain_clk_o <= 1'b0;
            chain_clk_oe <= 1'b0;
            mode <= `MODE_POR;
            secondary <= 1'b0;
            switching <= 1'b0;
            forced_pwm <= 1'b0;
            continuous_conduction <= 1'b0;
            comp_hold_low <= 1'b0;
            comp_drive <= 1'b0;
            err_amp_clamp <= 1'b0;
            out_discharge <= 1'b0;
            precise_enable <= 1'b0;
            window_cmp_en <= 1'b0;
            serial_if_en <= 1'b0;
            dynamic_voltage_scaling_en <= 1'b0;
            spread_spectrum_clocking_en <= 1'b0;
        end
        else
        begin
            en_o <= 1'b0;
            // Pull shared enable low while starting or faulted, not in POR
            en_oe <= stacked & (mode_q != `MODE_POR) & (starting | fault);
            pwr_good_line_o <= 1'b0;
            if (mode_q == `MODE_POR)
                pwr_good_line_oe <= 1'b0;
            else if (!init_done_q)
                pwr_good_line_oe <= 1'b1;
            else
                pwr_good_line_oe <= ~sec_q & ~pg_good;
            // Pin released during init so the strap can be read
            chain_clk_oe <= init_done_q;
            chain_clk_o <= init_done_q & (ph_q >= dly) & (ph_q < dly_end);
            mode <= mode_q;
            secondary <= sec_q;
            switching <= is_on;
            forced_pwm <= sec_q | ctrl_q[`CTRL_FPWM];
            continuous_conduction <= sec_q ? ccm_q : ctrl_q[`CTRL_FPWM];
            comp_hold_low <= ~sec_q & init_done_q & ~en_s;
            comp_drive <= ~sec_q & is_on & en_s;
            err_amp_clamp <= is_on & ilim;
            out_discharge <= disch_ok & disch_cfg;
            precise_enable <= ~stacked;
            window_cmp_en <= ~sec_q & init_done_q & (is_on | is_stby);
            serial_if_en <= ~sec_q & init_done_q;
            dynamic_voltage_scaling_en <= ~sec_q & is_on;
            spread_spectrum_clocking_en <= ~sec_q & ctrl_q[`CTRL_SSC];
        end
    end

endmodule

/* inc/stack_seq_defines.vh */
`ifndef STACK_SEQ_DEFINES_VH
`define STACK_SEQ_DEFINES_VH

// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STAT 12'h004

// Control register fields
`define CTRL_SWITCHING_ENABLE_BIT 0
`define CTRL_STANDALONE 1
`define CTRL_FPWM 2
`define CTRL_DISCH 3
`define CTRL_SSC 4
`define CTRL_W 5
`define CTRL_RST 5'h09

// Status register fields
`define STAT_MODE_LO 0
`define STAT_MODE_HI 2
`define STAT_SEC 3
`define STAT_INIT 4
`define STAT_CCM 5
`define STAT_EN 6
`define STAT_PG 7
`define STAT_FREQ_SELECT_PIN 8
`define STAT_VOLTAGE_SELECT_PIN 9

// Operating modes
`define MODE_POR 3'h0
`define MODE_UNDERVOLTAGE_LOCKOUT 3'h1
`define MODE_INIT 3'h2
`define MODE_STBY 3'h3
`define MODE_ON 3'h4

// Timing
`define PCLK_MHZ 100
`define INIT_TIME_US 400

// Chain clock phase: delay = period * 100 / 256, about 140 degrees
`define PHASE_MUL 8'h64
`define PHASE_SHIFT 8
// Sync, edge detect and output register add this many cycles to the chain pulse
`define CHAIN_LAT 10'h003

// Internal switching period and sync loss timeout in pclk cycles
`define SW_PERIOD_DEF 10'h010
`define SYNC_LOSS_DEF 10'h040

`endif

/* sim/stack_peer_model.sv */
`timescale 1ns/1ps
module stack_peer_model (
    input wire en_oe,
    input wire pwr_good_line_oe,
    input wire chain_clk_o,
    input wire chain_clk_oe,
    input wire peer_en_low,
    input wire peer_pg_low,
    input wire strap_low,
    input wire sync_run,
    output logic en_i,
    output logic pwr_good_line_i,
    output logic chain_clk_i,
    output logic mode_sync_i
);
    ////////////////////////////////////////
    // Shared lines have pull-ups; any party pulls them low
    assign en_i = !(en_oe || peer_en_low);
    assign pwr_good_line_i = !(pwr_good_line_oe || peer_pg_low);
    // Strap resistor only wins while the pin is undriven; keeper reads float high
    assign chain_clk_i = chain_clk_oe ? chain_clk_o : !strap_low;
    // Upstream chain clock, same frequency on every device, stands low when stopped
    initial mode_sync_i = 1'b0;
    always #80 mode_sync_i = sync_run ? !mode_sync_i : 1'b0;
endmodule

/* sim/stack_power_mode_sequencer_properties.sv */
`timescale 1ns/1ps
module stack_seq_checker #(
    parameter INIT_CYC = 40000
)(
    input wire pclk,
    input wire presetn,
    input wire supply_above_por,
    input wire supply_above_undervoltage_lockout,
    input wire thermal_shutdown,
    input wire [2:0] mode,
    input wire secondary,
    input wire forced_pwm,
    input wire pwr_good_line_oe,
    input wire precise_enable,
    input wire window_cmp_en,
    input wire serial_if_en,
    input wire dynamic_voltage_scaling_en
);
    localparam int LO = INIT_CYC - 3;
    localparam int HI = INIT_CYC + 3;
    logic [31:0] cnt_q;
    logic done_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    // Init length counter and a sticky flag cleared only by power-on reset
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q <= (mode == 3'h2) ? cnt_q + 1 : '0;
            done_q <= (mode == 3'h0) ? 1'b0 : (done_q || mode == 3'h3);
        end
    end
    a_secondary_fpwm: assert property (secondary |-> forced_pwm)
        else $error("secondary without forced pwm");
    a_role_held: assert property (mode inside {3'h3, 3'h4} && $past(mode) != 3'h0
        && $past(mode) != 3'h2 && $past(mode, 2) != 3'h2 |-> $stable(secondary))
        else $error("role changed after init");
    a_init_pg_low: assert property (mode == 3'h2 && $past(mode) == 3'h2
        |-> pwr_good_line_oe)
        else $error("power good not pulled during init");
    a_sec_pg_free: assert property (secondary && mode == 3'h3 && $past(mode) == 3'h3
        |-> !pwr_good_line_oe)
        else $error("secondary still pulls power good");
    a_primary_only: assert property (secondary
        |-> !(window_cmp_en || serial_if_en || dynamic_voltage_scaling_en))
        else $error("secondary runs primary-only function");
    a_binary_enable: assert property (secondary |-> !precise_enable)
        else $error("precise enable in stack");
    a_por_mode: assert property (!supply_above_por [*5] |-> mode == 3'h0)
        else $error("not in power-on reset mode");
    a_undervoltage_lockout_mode: assert property ((supply_above_por && !supply_above_undervoltage_lockout) [*5]
        |-> mode == 3'h1)
        else $error("not in lockout mode");
    a_hot_not_on: assert property (thermal_shutdown [*5] |-> mode != 3'h4)
        else $error("on mode while hot");
    a_init_time: assert property ($past(mode) == 3'h2 && mode == 3'h3
        |-> cnt_q >= LO && cnt_q <= HI)
        else $error("init length wrong");
    a_no_reinit: assert property (done_q |-> mode != 3'h2)
        else $error("init repeated without power-on reset");
endmodule
bind stack_power_mode_sequencer stack_seq_checker #(.INIT_CYC(INIT_CYC)) stack_seq_checker_inst (
    .pclk, .presetn, .supply_above_por, .supply_above_undervoltage_lockout, .thermal_shutdown, .mode,
    .secondary, .forced_pwm, .pwr_good_line_oe, .precise_enable, .window_cmp_en,
    .serial_if_en, .dynamic_voltage_scaling_en);

/* sim/stack_power_mode_sequencer_tb.sv */
`timescale 1ns/1ps
module stack_power_mode_sequencer_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic supply_above_por = 0, supply_above_undervoltage_lockout = 0, supply_above_overvoltage_lockout = 0;
    logic thermal_shutdown = 0, current_limit = 0, soft_start_done = 1, window_in_range = 1;
    logic freq_select_pin = 0, voltage_select_pin = 0, er;
    logic peer_en_low = 0, peer_pg_low = 0, strap_low = 0, sync_run = 0;
    wire [31:0] prdata;
    wire [2:0] mode;
    wire pready, pslverr, en_i, en_o, en_oe, pwr_good_line_i, pwr_good_line_o;
    wire pwr_good_line_oe, chain_clk_i, chain_clk_o, chain_clk_oe, mode_sync_i;
    wire secondary, switching, forced_pwm, continuous_conduction, comp_hold_low, comp_drive;
    wire err_amp_clamp, out_discharge, precise_enable, window_cmp_en, serial_if_en;
    wire dynamic_voltage_scaling_en, spread_spectrum_clocking_en;
    int mismatches = 0, check_count = 0, cyc = 0;
    ////////////////////////////////////////
    // Short init so the run stays brief
    stack_power_mode_sequencer #(.INIT_CYC(20)) stack_power_mode_sequencer_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .supply_above_por, .supply_above_undervoltage_lockout, .supply_above_overvoltage_lockout,
        .thermal_shutdown, .current_limit, .soft_start_done, .window_in_range, .en_i,
        .en_o, .en_oe, .pwr_good_line_i, .pwr_good_line_o, .pwr_good_line_oe,
        .chain_clk_i, .chain_clk_o, .chain_clk_oe, .mode_sync_i, .freq_select_pin,
        .voltage_select_pin, .mode, .secondary, .switching, .forced_pwm,
        .continuous_conduction, .comp_hold_low, .comp_drive, .err_amp_clamp,
        .out_discharge, .precise_enable, .window_cmp_en, .serial_if_en,
        .dynamic_voltage_scaling_en, .spread_spectrum_clocking_en);
    stack_peer_model stack_peer_model_inst (.en_oe, .pwr_good_line_oe, .chain_clk_o,
        .chain_clk_oe, .peer_en_low, .peer_pg_low, .strap_low, .sync_run, .en_i,
        .pwr_good_line_i, .chain_clk_i, .mode_sync_i);
    always #5 pclk = !pclk;
    // Hang guard, well above the expected few hundred cycles
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            results();
        end
    end
    task results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [32:0] g, input logic [32:0] e);
        check_count++;
        if (g !== e)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            mismatches++;
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Bounded wait; mode is compared when it arrives or the wait runs out
    task wait_mode(input logic [2:0] m);
        int n;
        n = 0;
        while (mode !== m && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        chk(mode, m);
    endtask
    // Request held until pready is seen high at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // No bound here: if pready never rises, only the bench timeout ends this wait
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task power_up(input logic sec);
        @(posedge pclk);
        presetn <= 0;
        supply_above_por <= 0;
        supply_above_undervoltage_lockout <= 0;
        strap_low <= sec;
        step(8);
        presetn <= 1;
        supply_above_por <= 1;
        step(6);
        chk(mode, 3'h1);
        supply_above_undervoltage_lockout <= 1;
        wait_mode(3'h2);
        step(3);
        chk(pwr_good_line_oe, 1);
        wait_mode(3'h3);
        chk(secondary, sec);
    endtask
    task test_registers();
        power_up(0);
        apb(0, 12'h000, 0);
        chk({er, rd}, 33'h0_0000_0009);
        apb(0, 12'h008, 0);
        chk({er, rd}, 33'h1_0000_0000);
        apb(1, 12'h004, 32'h0000_00ff);
        chk(er, 1);
        apb(1, 12'h000, 32'h0000_001c);
        apb(0, 12'h000, 0);
        chk({er, rd}, 33'h0_0000_001c);
        // Switching off, stacked: standby with discharge, spread spectrum and serial path
        chk({mode, out_discharge, spread_spectrum_clocking_en, window_cmp_en, serial_if_en,
            dynamic_voltage_scaling_en, precise_enable, forced_pwm}, {3'h3, 7'b1111001});
        $display("test registers done");
    endtask
    task test_primary();
        power_up(0);
        apb(1, 12'h000, 32'h0000_0005);
        wait_mode(3'h4);
        chk({switching, comp_hold_low, comp_drive}, 3'b101);
        current_limit <= 1;
        step(6);
        chk({mode, en_oe, err_amp_clamp}, {3'h4, 2'b01});
        current_limit <= 0;
        thermal_shutdown <= 1;
        wait_mode(3'h3);
        step(2);
        chk({en_oe, comp_hold_low}, 2'b11);
        thermal_shutdown <= 0;
        wait_mode(3'h4);
        supply_above_overvoltage_lockout <= 1;
        wait_mode(3'h3);
        supply_above_overvoltage_lockout <= 0;
        wait_mode(3'h4);
        supply_above_undervoltage_lockout <= 0;
        wait_mode(3'h1);
        supply_above_undervoltage_lockout <= 1;
        wait_mode(3'h4);
        apb(1, 12'h000, 32'h0000_0004);
        wait_mode(3'h3);
        supply_above_por <= 0;
        wait_mode(3'h0);
        $display("test primary done");
    endtask
    task test_secondary();
        time t0;
        sync_run <= 1;
        peer_pg_low <= 1;
        power_up(1);
        chk(forced_pwm, 1);
        apb(1, 12'h000, 32'h0000_0004);
        chk(er, 1);
        wait_mode(3'h4);
        chk(continuous_conduction, 0);
        peer_pg_low <= 0;
        step(6);
        chk(continuous_conduction, 1);
        chk({en_o, pwr_good_line_o, precise_enable}, 0);
        // Chain output trails the upstream rise by about 140 degrees of 160 ns
        @(posedge mode_sync_i);
        t0 = $time;
        @(posedge chain_clk_o);
        t0 = $time - t0;
        chk(chain_clk_oe, 1);
        chk(t0 >= 53 && t0 <= 71, 1);
        $display("test secondary done");
    endtask
    initial
    begin
        test_registers();
        test_primary();
        test_secondary();
        results();
    end
endmodule
